//--- hw/lpmc_defs.vh
// Constants for the low-power mode controller: register offsets, field positions, reset values, timing.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef LPMC_DEFS_VH
`define LPMC_DEFS_VH
`define LPMC_ADDR_W 8
`define LPMC_OFF_PROT 8'h00
`define LPMC_OFF_CLK0 8'h01
`define LPMC_OFF_CLK1 8'h02
`define LPMC_OFF_CLK2 8'h03
`define LPMC_OFF_DIV 8'h04
`define LPMC_OFF_PLL0 8'h05
`define LPMC_OFF_PLL1 8'h06
`define LPMC_OFF_MODE 8'h07
`define LPMC_OFF_LVL 8'h08
`define LPMC_OFF_CMD 8'h09
`define LPMC_OFF_STAT 8'h0A
`define LPMC_OFF_WAKE 8'h0B
// Protect register bits
`define LPMC_B_CLK_UNLOCK 0
`define LPMC_B_MODE_UNLOCK 1
// Clock register 0 bits
`define LPMC_B_CLOCK_OUTPUT_PIN_SEL 0
`define LPMC_B_WAIT_PSTOP 2
`define LPMC_B_MAIN_OFF 5
`define LPMC_B_SUB_SEL 7
// Clock register 1 bits
`define LPMC_B_ALL_STOP 0
`define LPMC_B_PLL_SEL 7
// Clock register 2 bits
`define LPMC_B_OSD_EN 0
`define LPMC_B_OCO_SEL 1
// PLL0 bit
`define LPMC_B_PLL_ON 7
// Mode register bits
`define LPMC_B_CLK_LOCK 1
`define LPMC_B_WDT_OCO 2
`define LPMC_B_EXT_BUS 3
// Command register bit
`define LPMC_B_WAIT_CMD 0
// Clock output select codes
`define LPMC_CO_PORT 2'h0
`define LPMC_CO_FC 2'h1
`define LPMC_CO_F8 2'h2
`define LPMC_CO_F32 2'h3
// Reset values and the divider code forced in stop mode
`define LPMC_RST_DIV 5'h08
`define LPMC_RST_LVL 3'h7
`define LPMC_DIV8_CODE 5'h08
// Oscillator settle time in ns and its cycle count at 20 MHz
`define LPMC_CLK_NS 50
`define LPMC_SETTLE_NS 2000000
`define LPMC_SETTLE_CYC ((`LPMC_SETTLE_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`endif

//--- hw/lpmc_sync.v
// Three-stage input synchroniser; a change counts once stages two and three agree.
// Assumes inputs asynchronous to sys_clk.
`timescale 1ns/1ps
module lpmc_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire sys_clk,
  input wire resetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] sync_d;
  genvar i;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Per-bit next value, so one process owns the whole output
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      assign sync_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sync_out[i];
    end
  endgenerate
  always @(posedge sys_clk) begin
    if (!resetn) begin
      sync_out <= INIT;
    end else begin
      sync_out <= sync_d;
    end
  end
endmodule

//--- hw/lpmc_top.v
// Low-power mode controller: wait and stop modes, wake-up qualification, clock gating and pin states.
// Assumes a single 20 MHz sys_clk, byte register port, wake sources arriving asynchronously.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "lpmc_defs.vh"
module lpmc_top #(
  parameter SETTLE_CYC = `LPMC_SETTLE_CYC
) (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [2:0] processor_priority_level,
  input wire nmi_n,
  input wire key_irq,
  input wire ext_irq,
  input wire serial_irq,
  input wire serial_ext_clk,
  input wire ad_irq,
  input wire ad_single_mode,
  input wire iio_irq,
  input wire timer_irq,
  input wire timer_event_mode,
  input wire timer_free_src,
  input wire [2:0] irq_priority_field,
  input wire fc_clk_in,
  input wire f8_clk_in,
  input wire f32_clk_in,
  output reg cpu_clk_en,
  output reg wdt_clk_en,
  output reg periph_clk_en,
  output reg free_clk_en,
  output reg main_osc_en,
  output reg sub_osc_en,
  output reg onchip_osc_en,
  output reg pll_en,
  output reg wake_pulse,
  output reg bus_hold,
  output reg strobe_force_high,
  output reg ale_out,
  output reg ale_force,
  output reg clock_output_pin,
  output reg xout_out,
  output reg xin_oe,
  output reg xcin_oe,
  output reg xcout_oe,
  output reg [4:0] cpu_clk_divider
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_STOP = 2'h2;
  localparam [1:0] ST_SETTLE = 2'h3;
  localparam CW = 22;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg clk_reg_write_unlock_q;
  reg mode_reg_write_unlock_q;
  reg [1:0] clock_output_pin_sel_q;
  reg wait_periph_clk_stop_q;
  reg main_osc_disable_q;
  reg sub_clk_select_q;
  reg pll_clk_select_q;
  reg osc_stop_detect_en_q;
  reg onchip_osc_select_q;
  reg [4:0] div_q;
  reg [7:0] pll0_q;
  reg [7:0] pll1_q;
  reg clock_change_lock_q;
  reg wdt_osc_source_sel_q;
  reg ext_bus_q;
  reg [2:0] exit_priority_level_q;
  reg [2:0] last_wake_q;
  reg [CW-1:0] settle_q;
  reg nmi_prev_q;

  wire [6:0] sync_o;
  wire nmi_s;
  wire key_s;
  wire ext_s;
  wire ser_s;
  wire ad_s;
  wire iio_s;
  wire tmr_s;
  wire fc_s;
  wire f8_s;
  wire f32_s;
  wire wr_clk;
  wire clk_ok;
  wire nmi_fall;
  wire lvl_ok;
  wire pstop;
  wire ser_ok;
  wire ad_ok;
  wire iio_ok;
  wire tmr_ok;
  wire wait_wake;
  wire stop_wake;
  wire co_src;
  wire co_free;

  lpmc_sync #(.W(7), .INIT(7'h01)) u_sync_irq (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({timer_irq, iio_irq, ad_irq, serial_irq, ext_irq, key_irq, nmi_n}),
    .sync_out(sync_o)
  );
  assign nmi_s = sync_o[0];
  assign key_s = sync_o[1];
  assign ext_s = sync_o[2];
  assign ser_s = sync_o[3];
  assign ad_s = sync_o[4];
  assign iio_s = sync_o[5];
  assign tmr_s = sync_o[6];

  // Clock pins synchronised too; only slow observation of the outputs matters
  wire [2:0] clk_sync_o;
  lpmc_sync #(.W(3), .INIT(3'h0)) u_sync_clk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({f32_clk_in, f8_clk_in, fc_clk_in}),
    .sync_out(clk_sync_o)
  );
  assign fc_s = clk_sync_o[0];
  assign f8_s = clk_sync_o[1];
  assign f32_s = clk_sync_o[2];

  assign wr_clk = reg_wr && clk_reg_write_unlock_q;
  assign clk_ok = !clock_change_lock_q;
  assign nmi_fall = nmi_prev_q && !nmi_s;
  assign lvl_ok = irq_priority_field > processor_priority_level;
  assign pstop = wait_periph_clk_stop_q;
  assign ser_ok = ser_s && (!pstop || serial_ext_clk);
  assign ad_ok = ad_s && ad_single_mode && !pstop;
  assign iio_ok = iio_s && !pstop;
  assign tmr_ok = tmr_s && (!pstop || timer_event_mode || timer_free_src);
  assign wait_wake = nmi_fall || (lvl_ok && (key_s || ext_s || ser_ok || ad_ok || iio_ok || tmr_ok));
  // Timer wake assumes the external pulse rate is slow enough to count unclocked
  assign stop_wake = nmi_fall || (lvl_ok && (key_s || ext_s || (tmr_s && timer_event_mode)));
  assign co_src = (clock_output_pin_sel_q == `LPMC_CO_FC) ? fc_s : (clock_output_pin_sel_q == `LPMC_CO_F8) ? f8_s : f32_s;
  assign co_free = (clock_output_pin_sel_q == `LPMC_CO_FC) || !pstop;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (wr_clk && clk_ok && reg_addr == `LPMC_OFF_CLK1 && reg_wdata[`LPMC_B_ALL_STOP]) begin
          state_d = ST_STOP;
        end else if (reg_wr && reg_addr == `LPMC_OFF_CMD && reg_wdata[`LPMC_B_WAIT_CMD] && clk_ok) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          state_d = ST_SETTLE;
        end
      end
      default: begin
        if (settle_q == 0) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_RUN;
      settle_q <= {CW{1'b0}};
      nmi_prev_q <= 1'b1;
      last_wake_q <= 3'h0;
      wake_pulse <= 1'b0;
    end else begin
      state_q <= state_d;
      nmi_prev_q <= nmi_s;
      wake_pulse <= (state_q == ST_WAIT || state_q == ST_STOP) && state_d != state_q;
      if (state_q == ST_STOP && state_d == ST_SETTLE) begin
        settle_q <= SETTLE_CYC[CW-1:0];
      end else if (settle_q != 0) begin
        settle_q <= settle_q - 1'b1;
      end
      if ((state_q == ST_WAIT || state_q == ST_STOP) && state_d != state_q) begin
        last_wake_q <= {nmi_fall, key_s || ext_s, !nmi_fall && !key_s && !ext_s};
      end
    end
  end

  // Register writes; clock bits need unlock, and all but the output select, on-chip select and divider also need no lock
  always @(posedge sys_clk) begin
    if (!resetn) begin
      clk_reg_write_unlock_q <= 1'b0;
      mode_reg_write_unlock_q <= 1'b0;
      clock_output_pin_sel_q <= `LPMC_CO_PORT;
      wait_periph_clk_stop_q <= 1'b0;
      main_osc_disable_q <= 1'b0;
      sub_clk_select_q <= 1'b0;
      pll_clk_select_q <= 1'b0;
      osc_stop_detect_en_q <= 1'b0;
      onchip_osc_select_q <= 1'b0;
      div_q <= `LPMC_RST_DIV;
      pll0_q <= 8'h00;
      pll1_q <= 8'h00;
      clock_change_lock_q <= 1'b0;
      wdt_osc_source_sel_q <= 1'b0;
      ext_bus_q <= 1'b0;
      exit_priority_level_q <= `LPMC_RST_LVL;
    end else begin
      if (reg_wr && reg_addr == `LPMC_OFF_PROT) begin
        clk_reg_write_unlock_q <= reg_wdata[`LPMC_B_CLK_UNLOCK];
        mode_reg_write_unlock_q <= reg_wdata[`LPMC_B_MODE_UNLOCK];
      end
      if (wr_clk && reg_addr == `LPMC_OFF_CLK0) begin
        clock_output_pin_sel_q <= reg_wdata[`LPMC_B_CLOCK_OUTPUT_PIN_SEL+1:`LPMC_B_CLOCK_OUTPUT_PIN_SEL];
        if (clk_ok) begin
          wait_periph_clk_stop_q <= reg_wdata[`LPMC_B_WAIT_PSTOP];
          main_osc_disable_q <= reg_wdata[`LPMC_B_MAIN_OFF];
          sub_clk_select_q <= reg_wdata[`LPMC_B_SUB_SEL];
        end
      end
      if (wr_clk && clk_ok && reg_addr == `LPMC_OFF_CLK1) begin
        pll_clk_select_q <= reg_wdata[`LPMC_B_PLL_SEL];
      end
      if (wr_clk && reg_addr == `LPMC_OFF_CLK2) begin
        onchip_osc_select_q <= reg_wdata[`LPMC_B_OCO_SEL];
        if (clk_ok) begin
          osc_stop_detect_en_q <= reg_wdata[`LPMC_B_OSD_EN];
        end
      end
      if (state_q == ST_RUN && state_d == ST_STOP) begin
        div_q <= `LPMC_DIV8_CODE;
      end else if (wr_clk && reg_addr == `LPMC_OFF_DIV) begin
        div_q <= reg_wdata[4:0];
      end
      if (wr_clk && clk_ok && reg_addr == `LPMC_OFF_PLL0) begin
        pll0_q <= reg_wdata;
      end
      if (wr_clk && clk_ok && reg_addr == `LPMC_OFF_PLL1) begin
        pll1_q <= reg_wdata;
      end
      if (reg_wr && mode_reg_write_unlock_q && reg_addr == `LPMC_OFF_MODE) begin
        clock_change_lock_q <= reg_wdata[`LPMC_B_CLK_LOCK];
        wdt_osc_source_sel_q <= reg_wdata[`LPMC_B_WDT_OCO];
        ext_bus_q <= reg_wdata[`LPMC_B_EXT_BUS];
      end
      if (reg_wr && reg_addr == `LPMC_OFF_LVL) begin
        exit_priority_level_q <= reg_wdata[2:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `LPMC_OFF_PROT) begin
        reg_rdata <= {6'h00, mode_reg_write_unlock_q, clk_reg_write_unlock_q};
      end else if (reg_addr == `LPMC_OFF_CLK0) begin
        reg_rdata <= {sub_clk_select_q, 1'b0, main_osc_disable_q, 2'h0, wait_periph_clk_stop_q, clock_output_pin_sel_q};
      end else if (reg_addr == `LPMC_OFF_CLK1) begin
        reg_rdata <= {pll_clk_select_q, 7'h00};
      end else if (reg_addr == `LPMC_OFF_CLK2) begin
        reg_rdata <= {6'h00, onchip_osc_select_q, osc_stop_detect_en_q};
      end else if (reg_addr == `LPMC_OFF_DIV) begin
        reg_rdata <= {3'h0, div_q};
      end else if (reg_addr == `LPMC_OFF_PLL0) begin
        reg_rdata <= pll0_q;
      end else if (reg_addr == `LPMC_OFF_PLL1) begin
        reg_rdata <= pll1_q;
      end else if (reg_addr == `LPMC_OFF_MODE) begin
        reg_rdata <= {4'h0, ext_bus_q, wdt_osc_source_sel_q, clock_change_lock_q, 1'b0};
      end else if (reg_addr == `LPMC_OFF_LVL) begin
        reg_rdata <= {5'h00, exit_priority_level_q};
      end else if (reg_addr == `LPMC_OFF_STAT) begin
        reg_rdata <= {6'h00, state_q};
      end else if (reg_addr == `LPMC_OFF_WAKE) begin
        reg_rdata <= {5'h00, last_wake_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Clock enables and pin controls, all registered
  always @(posedge sys_clk) begin
    if (!resetn) begin
      cpu_clk_en <= 1'b1;
      wdt_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      free_clk_en <= 1'b1;
      main_osc_en <= 1'b1;
      sub_osc_en <= 1'b1;
      onchip_osc_en <= 1'b1;
      pll_en <= 1'b0;
      bus_hold <= 1'b0;
      strobe_force_high <= 1'b0;
      ale_out <= 1'b0;
      ale_force <= 1'b0;
      clock_output_pin <= 1'b0;
      xout_out <= 1'b0;
      xin_oe <= 1'b1;
      xcin_oe <= 1'b1;
      xcout_oe <= 1'b1;
      cpu_clk_divider <= `LPMC_RST_DIV;
    end else begin
      cpu_clk_divider <= (state_d == ST_STOP) ? `LPMC_DIV8_CODE : div_q;
      cpu_clk_en <= (state_d == ST_RUN);
      wdt_clk_en <= (state_d == ST_RUN) || (state_d == ST_WAIT && wdt_osc_source_sel_q);
      periph_clk_en <= (state_d == ST_RUN) || (state_d == ST_WAIT && !pstop);
      free_clk_en <= (state_d == ST_RUN) || (state_d == ST_WAIT);
      main_osc_en <= (state_d != ST_STOP) && !main_osc_disable_q;
      sub_osc_en <= (state_d != ST_STOP);
      onchip_osc_en <= (state_d != ST_STOP);
      pll_en <= (state_d != ST_STOP) && pll0_q[`LPMC_B_PLL_ON];
      bus_hold <= ext_bus_q && (state_d == ST_WAIT || state_d == ST_STOP);
      strobe_force_high <= ext_bus_q && (state_d == ST_WAIT || state_d == ST_STOP);
      ale_force <= state_d == ST_STOP || (ext_bus_q && state_d == ST_WAIT);
      ale_out <= (state_d == ST_STOP);
      xout_out <= (state_d == ST_STOP);
      xin_oe <= (state_d != ST_STOP);
      xcin_oe <= (state_d != ST_STOP);
      xcout_oe <= (state_d != ST_STOP);
      // Holding last level avoids a runt edge when the source stops
      if (state_d == ST_STOP) begin
        if (clock_output_pin_sel_q == `LPMC_CO_FC) begin
          clock_output_pin <= 1'b1;
        end
      end else if (clock_output_pin_sel_q == `LPMC_CO_PORT) begin
        clock_output_pin <= 1'b0;
      end else if (state_d == ST_WAIT && !co_free) begin
        clock_output_pin <= clock_output_pin;
      end else begin
        clock_output_pin <= co_src;
      end
    end
  end
endmodule

//--- testbench/lpmc_checker.sv
// Port assertions for the low-power mode controller.
// Assumes a bind onto lpmc_top; sys_clk domain only.
`timescale 1ns/1ps
module lpmc_checker #(
  parameter SETTLE_CYC = 8
) (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire nmi_n,
  input wire cpu_clk_en,
  input wire periph_clk_en,
  input wire free_clk_en,
  input wire main_osc_en,
  input wire sub_osc_en,
  input wire onchip_osc_en,
  input wire pll_en,
  input wire wake_pulse,
  input wire bus_hold,
  input wire strobe_force_high,
  input wire ale_out,
  input wire xout_out,
  input wire xin_oe,
  input wire [4:0] cpu_clk_divider
);
  reg prot_q;
  reg stop_q;
  reg [15:0] settle_q;
  // Shadow of the unlock bit, since the checker cannot see inside
  always @(posedge sys_clk) begin
    if (!resetn)
      prot_q <= 1'b0;
    else if (reg_wr && reg_addr == 8'h00)
      prot_q <= reg_wdata[0];
  end
  // Counts settle cycles after stop; saturates
  always @(posedge sys_clk) begin
    if (!resetn)
      stop_q <= 1'b0;
    else if (!onchip_osc_en)
      stop_q <= 1'b1;
    else if (cpu_clk_en)
      stop_q <= 1'b0;
    if (!resetn || !onchip_osc_en)
      settle_q <= 16'h0000;
    else if (stop_q && !cpu_clk_en && settle_q != 16'hFFFF)
      settle_q <= settle_q + 16'h0001;
  end
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_STOP_DIV: assert property ($fell(onchip_osc_en) |-> cpu_clk_divider == 5'h08)
    else $error("divider not eight in stop");
  AST_STOP_ALL: assert property (!onchip_osc_en |-> !(main_osc_en || sub_osc_en || pll_en || cpu_clk_en || periph_clk_en))
    else $error("clock running in stop");
  AST_STOP_PIN: assert property (!onchip_osc_en |-> xout_out && !xin_oe)
    else $error("crystal pins wrong in stop");
  AST_SETTLE_MIN: assert property ($rose(cpu_clk_en) && stop_q |-> settle_q >= SETTLE_CYC - 1)
    else $error("cpu clock before settle");
  AST_SETTLE_HOLD: assert property ($rose(onchip_osc_en) && $past(resetn) |-> !cpu_clk_en [*3])
    else $error("cpu clock at oscillator restart");
  AST_SETTLE_MAX: assert property (stop_q && onchip_osc_en |-> settle_q <= SETTLE_CYC + 8)
    else $error("settle too long");
  AST_WAIT_OSC: assert property (!cpu_clk_en && main_osc_en && !stop_q |-> sub_osc_en && onchip_osc_en)
    else $error("oscillator stopped in wait");
  AST_FREE_CLK: assert property (!periph_clk_en && main_osc_en && !stop_q |-> free_clk_en)
    else $error("free clock stopped");
  AST_BUS_PINS: assert property (bus_hold && !stop_q |-> strobe_force_high && !ale_out)
    else $error("bus pins wrong in wait");
  AST_NMI_WAKE: assert property (!cpu_clk_en && !stop_q && $fell(nmi_n) |-> ##[1:10] wake_pulse)
    else $error("nmi did not wake");
  AST_WAKE_ONE: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  AST_DIV_LOCK: assert property (reg_wr && reg_addr == 8'h04 && !prot_q |=> ##1 $stable(cpu_clk_divider))
    else $error("divider written while locked");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

//--- testbench/lpmc_top_tb_top.sv
// Self-checking bench for lpmc_top: register port, wait, stop, lock.
// Assumes lpmc_defs.vh on the include path and a 20 MHz clock.
`timescale 1ns/1ps
module lpmc_top_tb_top;
  localparam SETTLE_CYC = 8;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [2:0] processor_priority_level = 3'h0;
  reg [2:0] irq_priority_field = 3'h0;
  reg nmi_n = 1'b1;
  reg key_irq = 1'b0, ext_irq = 1'b0, serial_irq = 1'b0, ad_irq = 1'b0, iio_irq = 1'b0, timer_irq = 1'b0;
  reg serial_ext_clk = 1'b0, ad_single_mode = 1'b0, timer_event_mode = 1'b0, timer_free_src = 1'b0;
  reg fc_clk_in = 1'b0, f8_clk_in = 1'b0, f32_clk_in = 1'b0;
  wire [7:0] reg_rdata;
  wire [4:0] cpu_clk_divider;
  wire cpu_clk_en, wdt_clk_en, periph_clk_en, free_clk_en, main_osc_en, sub_osc_en, onchip_osc_en, pll_en;
  wire wake_pulse, bus_hold, strobe_force_high, ale_out, ale_force, clock_output_pin;
  wire xout_out, xin_oe, xcin_oe, xcout_oe;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer m_div, t, i, p;
  reg [31:0] seed = 32'hD944;

  lpmc_top #(.SETTLE_CYC(SETTLE_CYC)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .processor_priority_level(processor_priority_level),
    .nmi_n(nmi_n), .key_irq(key_irq), .ext_irq(ext_irq), .serial_irq(serial_irq),
    .serial_ext_clk(serial_ext_clk), .ad_irq(ad_irq), .ad_single_mode(ad_single_mode), .iio_irq(iio_irq),
    .timer_irq(timer_irq), .timer_event_mode(timer_event_mode), .timer_free_src(timer_free_src),
    .irq_priority_field(irq_priority_field), .fc_clk_in(fc_clk_in), .f8_clk_in(f8_clk_in),
    .f32_clk_in(f32_clk_in), .cpu_clk_en(cpu_clk_en), .wdt_clk_en(wdt_clk_en), .periph_clk_en(periph_clk_en),
    .free_clk_en(free_clk_en), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .onchip_osc_en(onchip_osc_en), .pll_en(pll_en), .wake_pulse(wake_pulse), .bus_hold(bus_hold),
    .strobe_force_high(strobe_force_high), .ale_out(ale_out), .ale_force(ale_force),
    .clock_output_pin(clock_output_pin), .xout_out(xout_out), .xin_oe(xin_oe), .xcin_oe(xcin_oe),
    .xcout_oe(xcout_oe), .cpu_clk_divider(cpu_clk_divider)
  );

  always #25 sys_clk = ~sys_clk;
  // Slow asynchronous fc source so the clock output pin visibly toggles
  always #500 fc_clk_in = ~fc_clk_in;

  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction

  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk("rdata", e, reg_rdata);
    end
  endtask

  // Cycles until the cpu clock returns, bounded
  task await(input integer n);
    begin
      t = 0;
      while (cpu_clk_en !== 1'b1 && t < n) begin
        @(negedge sys_clk);
        t = t + 1;
      end
    end
  endtask

  // Bits: ext, timer, iio, ad, serial, key
  task pulse(input [5:0] v, input [7:0] w);
    begin
      @(posedge sys_clk);
      {ext_irq, timer_irq, iio_irq, ad_irq, serial_irq, key_irq} <= v;
      await(16);
      chk("woke", w, t < 16);
      @(posedge sys_clk);
      {ext_irq, timer_irq, iio_irq, ad_irq, serial_irq, key_irq} <= 6'h00;
      // Drain the synchronisers so a stale request cannot wake the next wait
      repeat (5) @(posedge sys_clk);
    end
  endtask

  task enter_wait;
    begin
      wr(8'h09, 8'h01);
      tick(2);
    end
  endtask

  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(1);
    m_div = 8;
    chk("clk_en", 8'h7F, {1'b0, cpu_clk_en, wdt_clk_en, periph_clk_en, free_clk_en, main_osc_en, sub_osc_en, onchip_osc_en});
    chk("pll", 8'h00, pll_en);
    chk("div", m_div, cpu_clk_divider);
    chk("osc_oe", 8'h07, {xin_oe, xcin_oe, xcout_oe});
    rd(8'h08, 8'h07);
    rd(8'hFF, 8'h00);
    wr(8'h04, 8'h02);
    tick(2);
    chk("div", m_div, cpu_clk_divider);
    wr(8'h00, 8'h03);
    seed = xs(seed);
    m_div = seed[1:0] + 1;
    wr(8'h04, m_div);
    tick(2);
    chk("div", m_div, cpu_clk_divider);
    wr(8'h05, 8'h00);
    // Wait with external bus, priority must beat the cpu level
    wr(8'h07, 8'h08);
    wr(8'h01, 8'h01);
    enter_wait;
    chk("wait_en", 8'h03, {cpu_clk_en, wdt_clk_en, periph_clk_en, main_osc_en});
    chk("bus", 8'h0D, {bus_hold, strobe_force_high, ale_out, ale_force});
    i = clock_output_pin;
    for (t = 0; clock_output_pin === i[0] && t < 40; t = t + 1)
      @(negedge sys_clk);
    chk("clock_output_pin", 8'h01, t < 40);
    seed = xs(seed);
    p = seed % 7;
    processor_priority_level <= p;
    irq_priority_field <= p;
    pulse(6'h01, 0);
    irq_priority_field <= p + 1;
    pulse(6'h01, 1);
    chk("div", m_div, cpu_clk_divider);
    // Peripheral clock stopped: only free-running sources wake
    irq_priority_field <= 3'h7;
    processor_priority_level <= 3'h0;
    ad_single_mode <= 1'b1;
    wr(8'h07, 8'h04);
    wr(8'h04, 8'h08);
    wr(8'h01, 8'h04);
    enter_wait;
    chk("pstop_en", 8'h05, {cpu_clk_en, wdt_clk_en, periph_clk_en, free_clk_en});
    for (i = 1; i < 5; i = i + 1)
      pulse(6'h01 << i, 0);
    timer_event_mode <= 1'b1;
    pulse(6'h10, 1);
    serial_ext_clk <= 1'b1;
    enter_wait;
    pulse(6'h02, 1);
    irq_priority_field <= 3'h0;
    enter_wait;
    @(posedge sys_clk);
    nmi_n <= 1'b0;
    await(16);
    chk("nmi_wake", 8'h01, t < 16);
    nmi_n <= 1'b1;
    rd(8'h0B, 8'h04);
    // Stop, then wake through the external pin after settling
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h01);
    tick(2);
    chk("div", 8'h08, cpu_clk_divider);
    chk("stop_en", 8'h00, {cpu_clk_en, periph_clk_en, main_osc_en, sub_osc_en, onchip_osc_en, pll_en});
    chk("stop_pin", 8'h08, {xout_out, xin_oe, xcin_oe, xcout_oe});
    chk("stop_co", 8'h07, {ale_out, ale_force, clock_output_pin});
    @(posedge sys_clk);
    irq_priority_field <= 3'h7;
    ext_irq <= 1'b1;
    await(40);
    ext_irq <= 1'b0;
    chk("stop_wake", 8'h01, t < 40);
    chk("settle", 8'h01, t >= SETTLE_CYC);
    rd(8'h0B, 8'h02);
    // Clock lock ignores stop and wait
    wr(8'h07, 8'h02);
    wr(8'h02, 8'h01);
    tick(2);
    chk("lock_osc", 8'h01, main_osc_en);
    enter_wait;
    chk("lock_cpu", 8'h01, cpu_clk_en);
    rd(8'h0A, 8'h00);
    test_done;
  end
endmodule

bind lpmc_top lpmc_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_n(nmi_n), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .free_clk_en(free_clk_en), .main_osc_en(main_osc_en),
  .sub_osc_en(sub_osc_en), .onchip_osc_en(onchip_osc_en), .pll_en(pll_en), .wake_pulse(wake_pulse),
  .bus_hold(bus_hold), .strobe_force_high(strobe_force_high), .ale_out(ale_out), .xout_out(xout_out),
  .xin_oe(xin_oe), .cpu_clk_divider(cpu_clk_divider)
);
